// [core/capture_unit_map.vh]
// Register offsets, field positions, mode codes and reset values of the capture unit
`ifndef CAPTURE_UNIT_MAP_VH
`define CAPTURE_UNIT_MAP_VH

// Register offsets on the plain register port
`define ADDR_MODE_CONTROL   3'h0
`define ADDR_HOLD_LOW       3'h1
`define ADDR_HOLD_HIGH      3'h2
`define ADDR_PERIPH_FLAG    3'h3
`define ADDR_IRQ_STATUS     3'h4
`define ADDR_IRQ_MASK       3'h5

// Mode control fields
`define MODE_LSB            0
`define MODE_MSB            3
`define FRAC_LO_BIT         4
`define FRAC_HI_BIT         5
`define CTRL_IMPL_MASK      8'h3f

// Peripheral flag register: unit flag position
`define UNIT_FLAG_BIT       2

// Interrupt status and mask layout
`define IRQ_CAPTURE_BIT     0
`define IRQ_MATCH_BIT       1
`define IRQ_SPECIAL_BIT     2
`define IRQ_WIDTH           3

// Mode select codes
`define MODE_OFF            4'h0
`define MODE_CAP_FALL       4'h4
`define MODE_CAP_RISE       4'h5
`define MODE_CAP_RISE4      4'h6
`define MODE_CAP_RISE16     4'h7
`define MODE_CMP_SET        4'h8
`define MODE_CMP_CLEAR      4'h9
`define MODE_CMP_SOFT       4'ha
`define MODE_CMP_SPECIAL    4'hb
`define MODE_GROUP_CAPTURE  2'h1
`define MODE_GROUP_COMPARE  2'h2
`define MODE_GROUP_PWM      2'h3

// Prescale terminal counts (divisor minus one)
`define PRESCALE_4          4'h3
`define PRESCALE_16         4'hf

// Reset values
`define RST_BYTE            8'h00
`define RST_WORD            16'h0000
`define RST_IRQ             3'h0
`define RST_NIBBLE          4'h0

// Port bits that can carry the unit pin
`define PIN_BIT_A           0
`define PIN_BIT_B           3

`endif

// [core/capture_edge_prescaler.v]
// Edge detector and capture prescaler of the capture unit
`timescale 1ns/1ns
`include "capture_unit_map.vh"

module capture_edge_prescaler #(
  parameter CNT_WIDTH = 4
) (
  // Clock and reset
  input  wire       mclk,
  input  wire       rst_n,
  // Control
  input  wire [3:0] modeSelect,
  // Synchronised pin level
  input  wire       pinLevel,
  // Capture event pulse
  output reg        captureEvent
);

  reg                 prevLevel;
  reg                 armed;
  reg [CNT_WIDTH-1:0] prescaleCount;

  wire captureMode = (modeSelect[3:2] == `MODE_GROUP_CAPTURE);
  wire risingEdge  = armed & pinLevel & ~prevLevel;
  wire fallingEdge = armed & ~pinLevel & prevLevel;

  reg [CNT_WIDTH-1:0] prescaleTop;
  always @* begin
    prescaleTop = {CNT_WIDTH{1'b0}};
    if (modeSelect == `MODE_CAP_RISE4) begin
      prescaleTop = `PRESCALE_4;
    end else if (modeSelect == `MODE_CAP_RISE16) begin
      prescaleTop = `PRESCALE_16;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n || !captureMode) begin
      // Off or not capturing: edge history and prescaler cleared
      prevLevel     <= 1'b0;
      armed         <= 1'b0;
      prescaleCount <= {CNT_WIDTH{1'b0}};
      captureEvent  <= 1'b0;
    end else begin
      prevLevel    <= pinLevel;
      armed        <= 1'b1;
      captureEvent <= 1'b0;
      case (modeSelect)
        `MODE_CAP_FALL: begin
          captureEvent <= fallingEdge;
        end
        `MODE_CAP_RISE: begin
          captureEvent <= risingEdge;
        end
        default: begin
          // Every 4th or 16th rising edge
          if (risingEdge) begin
            if (prescaleCount >= prescaleTop) begin
              prescaleCount <= {CNT_WIDTH{1'b0}};
              captureEvent  <= 1'b1;
            end else begin
              prescaleCount <= prescaleCount + 1'b1;
            end
          end
        end
      endcase
    end
  end

endmodule

// [core/capture_unit_mode_control.v]
// Mode control, capture and compare path of the capture/compare/PWM unit
`timescale 1ns/1ns
`include "capture_unit_map.vh"

module capture_unit_mode_control (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // Register port
  input  wire [2:0]  regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWrEn,
  input  wire        regRdEn,
  output reg  [7:0]  regRdData,
  // Timer one
  input  wire [15:0] timerOneCount,
  output reg         timerOneClear,
  output reg         adcStartConv,
  // Port pins and direction
  input  wire        pinLocationFuse,
  input  wire [7:0]  portDirectionReg,
  input  wire        portPinIn0,
  input  wire        portPinIn3,
  output reg         portPinOut0,
  output reg         portPinOe0,
  output reg         portPinOut3,
  output reg         portPinOe3,
  // PWM hand-off
  output reg         pwmActive,
  output reg  [1:0]  pwmDutyLsb,
  // Flags and interrupt
  output reg         unitIrqFlag,
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [5:0]           unitModeControl;
  reg  [7:0]           captureHoldLow;
  reg  [7:0]           captureHoldHigh;
  reg  [`IRQ_WIDTH-1:0] irqStatus;
  reg  [`IRQ_WIDTH-1:0] irqMask;
  reg                  compareOut;
  reg                  matchSeen;

  wire [3:0] modeSelect     = unitModeControl[`MODE_MSB:`MODE_LSB];
  wire       durationFracHi = unitModeControl[`FRAC_HI_BIT];
  wire       durationFracLo = unitModeControl[`FRAC_LO_BIT];
  wire       unitOff        = (modeSelect == `MODE_OFF);
  wire       captureMode    = (modeSelect[3:2] == `MODE_GROUP_CAPTURE);
  wire       compareMode    = (modeSelect[3:2] == `MODE_GROUP_COMPARE);
  wire       pwmMode        = (modeSelect[3:2] == `MODE_GROUP_PWM);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and location select

  reg pinSync0A;
  reg pinSync0B;
  reg pinSync3A;
  reg pinSync3B;
  reg fuseSyncA;
  reg fuseSyncB;

  always @(posedge mclk) begin
    if (!rst_n) begin
      pinSync0A <= 1'b0;
      pinSync0B <= 1'b0;
      pinSync3A <= 1'b0;
      pinSync3B <= 1'b0;
      fuseSyncA <= 1'b0;
      fuseSyncB <= 1'b0;
    end else begin
      pinSync0A <= portPinIn0;
      pinSync0B <= pinSync0A;
      pinSync3A <= portPinIn3;
      pinSync3B <= pinSync3A;
      fuseSyncA <= pinLocationFuse;
      fuseSyncB <= fuseSyncA;
    end
  end

  // Fuse high puts the unit pin on port bit 0, low on port bit 3
  wire pinOnBitA = fuseSyncB;

  // The pad level is sampled whatever the direction bit says
  wire unitPinLevel = pinOnBitA ? pinSync0B : pinSync3B;

  wire unitPinDirIn = pinOnBitA ? portDirectionReg[`PIN_BIT_A]
                                : portDirectionReg[`PIN_BIT_B];

  ////////////////////////////////////////////////////////////////////////////
  // Capture edge detection and prescaler

  wire captureEvent;

  capture_edge_prescaler #(
    .CNT_WIDTH (4)
  ) u_edge (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .modeSelect   (modeSelect),
    .pinLevel     (unitPinLevel),
    .captureEvent (captureEvent)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare match

  wire timerEqual = compareMode &&
                    (timerOneCount == {captureHoldHigh, captureHoldLow});
  // One pulse per match, not one per cycle that the count rests on it
  wire matchEvent = timerEqual & ~matchSeen;
  wire specialEvent = matchEvent && (modeSelect == `MODE_CMP_SPECIAL);

  always @(posedge mclk) begin
    if (!rst_n || unitOff) begin
      matchSeen <= 1'b0;
    end else begin
      matchSeen <= timerEqual;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n || unitOff) begin
      compareOut <= 1'b0;
    end else if (matchEvent) begin
      if (modeSelect == `MODE_CMP_SET) begin
        compareOut <= 1'b1;
      end else if (modeSelect == `MODE_CMP_CLEAR) begin
        compareOut <= 1'b0;
      end
      // Soft-interrupt and special-event settings leave the latch alone
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      timerOneClear <= 1'b0;
      adcStartConv  <= 1'b0;
    end else begin
      timerOneClear <= specialEvent;
      adcStartConv  <= specialEvent;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  wire wrControl  = regWrEn && (regAddr == `ADDR_MODE_CONTROL);
  wire wrHoldLow  = regWrEn && (regAddr == `ADDR_HOLD_LOW);
  wire wrHoldHigh = regWrEn && (regAddr == `ADDR_HOLD_HIGH);
  wire wrFlag     = regWrEn && (regAddr == `ADDR_PERIPH_FLAG);
  wire wrMask     = regWrEn && (regAddr == `ADDR_IRQ_MASK);
  wire rdStatus   = regRdEn && (regAddr == `ADDR_IRQ_STATUS);

  always @(posedge mclk) begin
    if (!rst_n) begin
      unitModeControl <= 6'h00;
    end else if (wrControl) begin
      unitModeControl <= regWrData[5:0];
    end
  end

  // Capture wins over a software write in the same cycle
  always @(posedge mclk) begin
    if (!rst_n) begin
      captureHoldLow  <= `RST_BYTE;
      captureHoldHigh <= `RST_BYTE;
    end else if (captureEvent && captureMode) begin
      captureHoldLow  <= timerOneCount[7:0];
      captureHoldHigh <= timerOneCount[15:8];
    end else begin
      if (wrHoldLow) begin
        captureHoldLow <= regWrData;
      end
      if (wrHoldHigh) begin
        captureHoldHigh <= regWrData;
      end
    end
  end

  wire flagSet = (captureEvent && captureMode) || matchEvent;

  // Hardware only sets the flag; a set beats a clearing write
  always @(posedge mclk) begin
    if (!rst_n) begin
      unitIrqFlag <= 1'b0;
    end else if (flagSet) begin
      unitIrqFlag <= 1'b1;
    end else if (wrFlag) begin
      unitIrqFlag <= regWrData[`UNIT_FLAG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and output

  wire [`IRQ_WIDTH-1:0] irqEvents;
  assign irqEvents[`IRQ_CAPTURE_BIT] = captureEvent && captureMode;
  assign irqEvents[`IRQ_MATCH_BIT]   = matchEvent;
  assign irqEvents[`IRQ_SPECIAL_BIT] = specialEvent;

  // A read clears the status, but an event in that cycle stays set
  wire [`IRQ_WIDTH-1:0] next_irqStatus = (rdStatus ? `RST_IRQ : irqStatus) | irqEvents;

  // New mask takes effect on the output in the cycle it is written
  wire [`IRQ_WIDTH-1:0] next_irqMask = wrMask ? regWrData[`IRQ_WIDTH-1:0] : irqMask;

  always @(posedge mclk) begin
    if (!rst_n) begin
      irqStatus <= `RST_IRQ;
      irqMask   <= `RST_IRQ;
      irq       <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus;
      irqMask   <= next_irqMask;
      irq       <= |(next_irqStatus & next_irqMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe

  reg [7:0] next_regRdData;

  always @* begin
    next_regRdData = `RST_BYTE;
    if (regAddr == `ADDR_MODE_CONTROL) begin
      next_regRdData = {2'b00, unitModeControl} & `CTRL_IMPL_MASK;
    end else if (regAddr == `ADDR_HOLD_LOW) begin
      next_regRdData = captureHoldLow;
    end else if (regAddr == `ADDR_HOLD_HIGH) begin
      next_regRdData = captureHoldHigh;
    end else if (regAddr == `ADDR_PERIPH_FLAG) begin
      next_regRdData[`UNIT_FLAG_BIT] = unitIrqFlag;
    end else if (regAddr == `ADDR_IRQ_STATUS) begin
      next_regRdData[`IRQ_WIDTH-1:0] = irqStatus;
    end else if (regAddr == `ADDR_IRQ_MASK) begin
      next_regRdData[`IRQ_WIDTH-1:0] = irqMask;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      regRdData <= `RST_BYTE;
    end else if (regRdEn) begin
      regRdData <= next_regRdData;
    end else begin
      regRdData <= `RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and PWM hand-off

  // The unit drives its pin only in compare or PWM mode with direction output
  wire driveEnable = (compareMode || pwmMode) && !unitPinDirIn;

  always @(posedge mclk) begin
    if (!rst_n) begin
      portPinOut0 <= 1'b0;
      portPinOe0  <= 1'b0;
      portPinOut3 <= 1'b0;
      portPinOe3  <= 1'b0;
      pwmActive   <= 1'b0;
      pwmDutyLsb  <= 2'b00;
    end else begin
      portPinOut0 <= pinOnBitA & compareOut;
      portPinOe0  <= pinOnBitA & driveEnable;
      portPinOut3 <= ~pinOnBitA & compareOut;
      portPinOe3  <= ~pinOnBitA & driveEnable;
      pwmActive   <= pwmMode;
      // Fraction bits matter only in PWM mode
      pwmDutyLsb  <= pwmMode ? {durationFracHi, durationFracLo} : 2'b00;
    end
  end

endmodule

// [testbench/capture_unit_checker.sv]
// Port assertions of the capture unit mode control block
`timescale 1ns/1ns
module capture_unit_checker (
  // Clock and reset
  input wire       mclk,
  input wire       rst_n,
  // Register port
  input wire [2:0] regAddr,
  input wire [7:0] regWrData,
  input wire       regWrEn,
  input wire       regRdEn,
  input wire [7:0] regRdData,
  // Unit outputs
  input wire       timerOneClear,
  input wire       adcStartConv,
  input wire       portPinOe0,
  input wire       portPinOe3,
  input wire       pwmActive,
  input wire [1:0] pwmDutyLsb,
  input wire       unitIrqFlag
);
  reg [5:0] ctrl;
  reg [1:0] age;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Control shadow and cycles since its last write
  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrl <= 6'h00;
      age  <= 2'h3;
    end else if (regWrEn && regAddr == 3'h0) begin
      ctrl <= regWrData[5:0];
      age  <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_ctrl_top_zero: assert property (
    $past(regRdEn) && $past(regAddr) == 3'h0 |-> regRdData[7:6] == 2'h0)
    else $error("control read shows upper bits");
  a_rd_unmapped: assert property (
    $past(regRdEn) && $past(regAddr) > 3'h5 |-> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rd_idle: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data outside read cycle");
  a_trig_pulse: assert property (
    timerOneClear |-> adcStartConv && $past(ctrl[3:0]) == 4'hb ##1 !timerOneClear)
    else $error("special trigger wrong");
  a_flag_clear: assert property (
    $fell(unitIrqFlag) |-> $past(regWrEn) && $past(regAddr) == 3'h3 && !$past(regWrData[2]))
    else $error("flag cleared by hardware");
  a_oe_single: assert property (!(portPinOe0 && portPinOe3))
    else $error("both pins driven");
  a_oe_mode: assert property (
    portPinOe0 || portPinOe3 |-> $past(ctrl[3]) || $past(ctrl[3], 2))
    else $error("pin driven outside compare or pwm");
  a_pwm_follow: assert property (
    age == 2'h3 |-> pwmActive == (ctrl[3:2] == 2'h3)
      && pwmDutyLsb == ((ctrl[3:2] == 2'h3) ? ctrl[5:4] : 2'h0))
    else $error("pwm outputs disagree with control");
  c_trig: cover property (timerOneClear);
  c_pwm: cover property (pwmActive);
  c_flag: cover property ($rose(unitIrqFlag));
endmodule

// [testbench/capture_pin_source.sv]
// Outside signal source driving the two candidate capture pins
`timescale 1ns/1ns
module capture_pin_source (
  // Clock
  input wire mclk,
  // Pin levels
  output reg pinLevel0,
  output reg pinLevel3
);
  initial begin
    pinLevel0 = 1'b0;
    pinLevel3 = 1'b0;
  end
  // One high pulse, each level held long enough to pass the synchroniser
  task automatic pulse(input bit sel3, input int hold);
    begin
      @(posedge mclk);
      if (sel3) pinLevel3 <= 1'b1;
      else pinLevel0 <= 1'b1;
      repeat (hold) @(posedge mclk);
      if (sel3) pinLevel3 <= 1'b0;
      else pinLevel0 <= 1'b0;
      repeat (hold) @(posedge mclk);
    end
  endtask
endmodule

// [testbench/capture_unit_mode_control_tb.sv]
// Self-checking bench of the capture unit mode control block
`timescale 1ns/1ns
`include "capture_unit_map.vh"
module capture_unit_mode_control_tb;
  reg         mclk;
  reg         rst_n;
  reg  [2:0]  regAddr;
  reg  [7:0]  regWrData;
  reg         regWrEn;
  reg         regRdEn;
  wire [7:0]  regRdData;
  reg  [15:0] timerOneCount;
  reg         pinLocationFuse;
  reg  [7:0]  portDirectionReg;
  wire        pin0, pin3, out0, oe0, out3, oe3;
  wire        timerOneClear, adcStartConv, pwmActive, unitIrqFlag, irq;
  wire [1:0]  pwmDutyLsb;
  integer     error_cnt, n_checks, cycles, k;

  capture_unit_mode_control u_dut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .timerOneCount(timerOneCount), .timerOneClear(timerOneClear),
    .adcStartConv(adcStartConv), .pinLocationFuse(pinLocationFuse),
    .portDirectionReg(portDirectionReg), .portPinIn0(pin0), .portPinIn3(pin3),
    .portPinOut0(out0), .portPinOe0(oe0), .portPinOut3(out3), .portPinOe3(oe3),
    .pwmActive(pwmActive), .pwmDutyLsb(pwmDutyLsb), .unitIrqFlag(unitIrqFlag), .irq(irq));
  capture_pin_source u_src (.mclk(mclk), .pinLevel0(pin0), .pinLevel3(pin3));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task test_done;
    begin
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task check(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task do_reset;
    begin
      rst_n <= 1'b0;
      tick(5);
      rst_n <= 1'b1;
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge mclk);
      regWrEn <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, input [7:0] e);
    begin
      @(posedge mclk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge mclk);
      regRdEn <= 1'b0;
      @(negedge mclk);
      check(regRdData, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    begin
      rd(`ADDR_MODE_CONTROL, 8'h00);
      rd(`ADDR_IRQ_MASK, 8'h00);
      wr(`ADDR_MODE_CONTROL, 8'hff);
      rd(`ADDR_MODE_CONTROL, 8'h3f);
      check(pwmDutyLsb, 2'h3);
      for (k = 0; k < 4; k = k + 1) begin
        wr(`ADDR_MODE_CONTROL, 8'h0c | k[7:0]);
        tick(3);
        check(pwmActive, 1'b1);
      end
      wr(`ADDR_MODE_CONTROL, 8'h34);
      tick(3);
      check({pwmActive, pwmDutyLsb}, 3'h0);
      rd(3'h6, 8'h00);
      rd(3'h7, 8'h00);
    end
  endtask
  task t_capture(input [3:0] m, input integer d);
    integer i;
    begin
      wr(`ADDR_MODE_CONTROL, 8'h00);
      portDirectionReg <= 8'hff;
      wr(`ADDR_MODE_CONTROL, {4'h0, m});
      wr(`ADDR_PERIPH_FLAG, 8'h00);
      tick(4);
      for (i = 1; i <= 2 * d; i = i + 1) begin
        timerOneCount <= {m, 12'h000} + i[15:0];
        u_src.pulse(1'b0, 6);
        check(unitIrqFlag, i >= d);
      end
      rd(`ADDR_HOLD_LOW, 2 * d);
      rd(`ADDR_HOLD_HIGH, {m, 4'h0});
      check(unitIrqFlag, 1'b1);
    end
  endtask
  task cmp(input [3:0] m, input e);
    integer i;
    begin
      wr(`ADDR_MODE_CONTROL, {4'h0, m});
      wr(`ADDR_PERIPH_FLAG, 8'h00);
      timerOneCount <= 16'h1234;
      @(negedge mclk);
      for (i = 0; i < 8 && unitIrqFlag !== 1'b1; i = i + 1) @(negedge mclk);
      check({timerOneClear, adcStartConv}, {2{m == 4'hb}});
      tick(3);
      check({unitIrqFlag, out0, oe0}, {1'b1, e, 1'b1});
      timerOneCount <= 16'h0000;
    end
  endtask
  task t_compare;
    begin
      @(posedge mclk);
      portDirectionReg <= 8'hfe;
      timerOneCount <= 16'h0000;
      rd(`ADDR_IRQ_STATUS, 8'h01);
      wr(`ADDR_HOLD_LOW, 8'h34);
      wr(`ADDR_HOLD_HIGH, 8'h12);
      cmp(`MODE_CMP_SET, 1'b1);
      cmp(`MODE_CMP_SOFT, 1'b1);
      cmp(`MODE_CMP_CLEAR, 1'b0);
      wr(`ADDR_IRQ_MASK, 8'h04);
      cmp(`MODE_CMP_SPECIAL, 1'b0);
      check(irq, 1'b1);
      wr(`ADDR_IRQ_MASK, 8'h00);
      tick(2);
      check(irq, 1'b0);
      rd(`ADDR_IRQ_STATUS, 8'h06);
      rd(`ADDR_IRQ_STATUS, 8'h00);
      cmp(`MODE_CMP_SET, 1'b1);
      wr(`ADDR_MODE_CONTROL, 8'h00);
      tick(3);
      check({out0, oe0}, 2'h0);
    end
  endtask
  task t_fuse;
    begin
      pinLocationFuse <= 1'b0;
      portDirectionReg <= 8'h00;
      do_reset;
      wr(`ADDR_MODE_CONTROL, {4'h0, `MODE_CAP_RISE});
      tick(4);
      u_src.pulse(1'b0, 6);
      check(unitIrqFlag, 1'b0);
      u_src.pulse(1'b1, 6);
      check({unitIrqFlag, oe3, out3}, 3'h4);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    n_checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    timerOneCount = 16'h0000;
    pinLocationFuse = 1'b1;
    portDirectionReg = 8'hff;
    do_reset;
    t_regs;
    t_capture(`MODE_CAP_FALL, 1);
    t_capture(`MODE_CAP_RISE, 1);
    t_capture(`MODE_CAP_RISE4, 4);
    t_capture(`MODE_CAP_RISE16, 16);
    t_compare;
    t_fuse;
    test_done;
  end
endmodule

bind capture_unit_mode_control capture_unit_checker u_chk (.mclk, .rst_n, .regAddr,
  .regWrData, .regWrEn, .regRdEn, .regRdData, .timerOneClear, .adcStartConv,
  .portPinOe0, .portPinOe3, .pwmActive, .pwmDutyLsb, .unitIrqFlag);
